// file: pbba_annunciator.sv
// power-on self-test beep and blink annunciator top
// Operation
// - speaker tone bursts encode event type
// - cpu init done: one 0.5 s 3270 Hz
// - self-test done: one 0.5 s 3270 Hz
// - video: two bursts, 3 s pause, repeat
// - video pattern only on video error
// - memory: three 1280 Hz bursts, repeat forever
// - thermal: groups of four, stop after sixteen
// - power led blinks encode event type
// - init/self-test done: led off 0.5 s
// - update: led blinks, speaker silent
// - video: led two blinks, 3 s off
// - memory: led three blinks, 3 s off
// - thermal: led groups of four, sixteen total
`timescale 1ns/10ps
module pbba_annunciator
    import pbba_pkg::*;
#(
    parameter int unsigned HALF_CYC  = HALF_SEC_CYC,
    parameter int unsigned PAUSE_LEN = PAUSE_CYC
) (
    // clock, reset, enable
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_NRST,
    input  wire logic       I_CE,
    // firmware request
    input  wire pbba_req_t  I_REQ,
    input  wire logic       I_UPDATE_DONE,
    // annunciator outputs
    output logic            O_SPEAKER,
    output logic            O_POWER_LED,
    output logic            O_BUSY
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        PBBA_S_IDLE  = 5'b00001,
        PBBA_S_ON    = 5'b00010,
        PBBA_S_OFF   = 5'b00100,
        PBBA_S_PAUSE = 5'b01000,
        PBBA_S_DONE  = 5'b10000
    } pbba_state_t;

    pbba_state_t   state_q;
    pbba_event_t   ev_q;
    logic [TW-1:0] tmr_q;
    logic [2:0]    burst_q;
    logic [4:0]    total_q;
    logic          tone_en_q;
    logic [FW-1:0] half_q;
    logic          wave;

    // bursts per group for the repeating error patterns
    function automatic logic [2:0] group_len(input pbba_event_t e);
        case (e)
            PBBA_EV_VIDEO:   group_len = VIDEO_BURSTS;
            PBBA_EV_MEMORY:  group_len = MEMORY_BURSTS;
            PBBA_EV_THERMAL: group_len = THERMAL_BURSTS;
            default:         group_len = 3'h1;
        endcase
    endfunction

    // events that sound the speaker; update stays silent
    function automatic logic audible(input pbba_event_t e);
        audible = (e != PBBA_EV_UPDATE) && (e != PBBA_EV_NONE);
    endfunction

    // a request counts only with a real event code; code zero is ignored
    function automatic logic taken(input pbba_req_t r);
        taken = r.valid && (r.code != PBBA_EV_NONE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pattern sequencer; any new request restarts from the first step
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            state_q <= PBBA_S_IDLE;
            ev_q    <= PBBA_EV_NONE;
            tmr_q   <= '0;
            burst_q <= '0;
            total_q <= '0;
        end else if (I_CE) begin
            if (taken(I_REQ)) begin
                ev_q    <= I_REQ.code;
                tmr_q   <= '0;
                burst_q <= '0;
                total_q <= '0;
                // update begins with led off; init/done begin the led-off gap
                state_q <= (I_REQ.code == PBBA_EV_UPDATE) ? PBBA_S_OFF : PBBA_S_ON;
            end else begin
                case (state_q)
                    PBBA_S_ON: begin
                        if (tmr_q >= TW'(HALF_CYC - 1)) begin
                            tmr_q   <= '0;
                            // update phases never form groups, so they leave burst_q alone; total_q still counts them
                            if (ev_q != PBBA_EV_UPDATE)
                                burst_q <= burst_q + 3'h1;
                            total_q <= total_q + 5'h01;
                            if (ev_q == PBBA_EV_CPU_OK || ev_q == PBBA_EV_SELF_OK)
                                state_q <= PBBA_S_DONE;
                            else
                                state_q <= PBBA_S_OFF;
                        end else begin
                            tmr_q <= tmr_q + TW'(1);
                        end
                    end
                    PBBA_S_OFF: begin
                        if (tmr_q >= TW'(HALF_CYC - 1)) begin
                            tmr_q <= '0;
                            if (ev_q == PBBA_EV_UPDATE)
                                state_q <= PBBA_S_ON;
                            else if (ev_q == PBBA_EV_THERMAL && total_q == THERMAL_LIMIT)
                                state_q <= PBBA_S_DONE;
                            else if (burst_q == group_len(ev_q))
                                state_q <= PBBA_S_PAUSE;
                            else
                                state_q <= PBBA_S_ON;
                        end else begin
                            tmr_q <= tmr_q + TW'(1);
                        end
                    end
                    PBBA_S_PAUSE: begin
                        if (tmr_q >= TW'(PAUSE_LEN - 1)) begin
                            tmr_q   <= '0;
                            burst_q <= '0;
                            state_q <= PBBA_S_ON;
                        end else begin
                            tmr_q <= tmr_q + TW'(1);
                        end
                    end
                    PBBA_S_IDLE, PBBA_S_DONE: tmr_q <= '0;
                    default: state_q <= PBBA_S_IDLE;
                endcase
            end
            // update ends once firmware reports completion
            if (ev_q == PBBA_EV_UPDATE && I_UPDATE_DONE && !I_REQ.valid) begin
                state_q <= PBBA_S_DONE;
                tmr_q   <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tone select: 3270 Hz for healthy/video, 1280 Hz for memory/thermal
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            tone_en_q <= 1'b0;
            half_q    <= FW'(TONE_HI_HALF);
        end else if (I_CE) begin
            // a fresh request mutes the divider for one cycle so its tone starts clean
            tone_en_q <= (state_q == PBBA_S_ON) && audible(ev_q)
                         && !taken(I_REQ);
            half_q    <= (ev_q == PBBA_EV_MEMORY || ev_q == PBBA_EV_THERMAL)
                         ? FW'(TONE_LO_HALF) : FW'(TONE_HI_HALF);
        end
    end

    pbba_tone u_tone (
        .i_clk  (I_CLK_SYS),
        .i_nrst (I_NRST),
        .i_ce   (I_CE),
        .i_on   (tone_en_q),
        .i_half (half_q),
        .o_wave (wave)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs; led lit from power-up; init/done darken it only in their gap, other events light it only in PBBA_S_ON
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_SPEAKER   <= 1'b0;
            O_POWER_LED <= 1'b1;
            O_BUSY      <= 1'b0;
        end else if (I_CE) begin
            O_SPEAKER <= wave;
            O_BUSY    <= (state_q != PBBA_S_IDLE) && (state_q != PBBA_S_DONE);
            if (ev_q == PBBA_EV_CPU_OK || ev_q == PBBA_EV_SELF_OK)
                O_POWER_LED <= (state_q != PBBA_S_ON);
            else if (ev_q == PBBA_EV_NONE)
                O_POWER_LED <= 1'b1;
            else
                O_POWER_LED <= (state_q == PBBA_S_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the sequencer and the tone enable
    sequence s_on_end;
        state_q == PBBA_S_ON && tmr_q == TW'(HALF_CYC - 1) && !I_REQ.valid;
    endsequence

    sequence s_taken;
        I_CE && taken(I_REQ);
    endsequence

    sequence s_update_stop;
        I_CE && ev_q == PBBA_EV_UPDATE && I_UPDATE_DONE && !I_REQ.valid;
    endsequence

    a_silent_update: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        ev_q == PBBA_EV_UPDATE |-> !tone_en_q)
        else $error("speaker enabled during update");
    a_thermal_stop: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        ev_q == PBBA_EV_THERMAL |-> total_q <= THERMAL_LIMIT)
        else $error("thermal pattern exceeded sixteen bursts");
    a_single_beep: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        (s_on_end and (I_CE && ev_q == PBBA_EV_CPU_OK)) ##1 I_CE |->
            state_q == PBBA_S_DONE)
        else $error("init beep not single");
    a_burst_count: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        burst_q <= THERMAL_BURSTS)
        else $error("burst counter out of range");
    a_restart_req: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        I_CE && I_REQ.valid && I_REQ.code == PBBA_EV_VIDEO |=>
            ev_q == PBBA_EV_VIDEO && burst_q == 3'h0 && state_q == PBBA_S_ON)
        else $error("request did not restart pattern");
    a_restart_tone: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        s_taken |=> !tone_en_q)
        else $error("tone divider not restarted by request");
    a_update_end: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        s_update_stop |=> state_q == PBBA_S_DONE)
        else $error("update blink did not stop");
    a_pause_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_NRST)
        I_CE && state_q == PBBA_S_PAUSE |=> !tone_en_q)
        else $error("tone enabled during pause");
endmodule

// file: pbba_pkg.sv
// package: event codes, timing constants and carrier types for the annunciator
package pbba_pkg;
    // clock rate and documented times
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned HALF_SEC_MS   = 500;
    localparam int unsigned PAUSE_MS      = 3000;
    localparam int unsigned TONE_HI_HZ    = 3270;
    localparam int unsigned TONE_LO_HZ    = 1280;
    // derived cycle counts (intervals round down, half-periods round down)
    localparam int unsigned HALF_SEC_CYC  = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam int unsigned PAUSE_CYC     = CLK_HZ / 1000 * PAUSE_MS;
    localparam int unsigned TONE_HI_HALF  = CLK_HZ / (2 * TONE_HI_HZ);
    localparam int unsigned TONE_LO_HALF  = CLK_HZ / (2 * TONE_LO_HZ);
    // pattern shape
    localparam logic [2:0] VIDEO_BURSTS   = 3'h2;
    localparam logic [2:0] MEMORY_BURSTS  = 3'h3;
    localparam logic [2:0] THERMAL_BURSTS = 3'h4;
    localparam logic [4:0] THERMAL_LIMIT  = 5'h10;
    localparam int unsigned TW            = 32;
    localparam int unsigned FW            = 16;

    // event codes requested by the firmware
    typedef enum logic [2:0] {
        PBBA_EV_NONE    = 3'h0,
        PBBA_EV_CPU_OK  = 3'h1,
        PBBA_EV_SELF_OK = 3'h2,
        PBBA_EV_UPDATE  = 3'h3,
        PBBA_EV_VIDEO   = 3'h4,
        PBBA_EV_MEMORY  = 3'h5,
        PBBA_EV_THERMAL = 3'h6
    } pbba_event_t;

    // request carrier: one-cycle strobe with event code
    typedef struct packed {
        logic        valid;
        pbba_event_t code;
    } pbba_req_t;
endpackage

// file: pbba_tone.sv
// square-wave tone generator with a programmable half period
`timescale 1ns/10ps
module pbba_tone
    import pbba_pkg::*;
(
    // clock, reset, enable
    input  wire logic          i_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_ce,
    // control
    input  wire logic          i_on,
    input  wire logic [FW-1:0] i_half,
    // tone output
    output logic               o_wave
);
    logic [FW-1:0] cnt_q;

    // divider restarts while silent so each burst begins on a clean edge
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt_q  <= '0;
            o_wave <= 1'b0;
        end else if (i_ce) begin
            if (!i_on) begin
                cnt_q  <= '0;
                o_wave <= 1'b0;
            end else if (cnt_q >= i_half - FW'(1)) begin
                cnt_q  <= '0;
                o_wave <= ~o_wave;
            end else begin
                cnt_q <= cnt_q + FW'(1);
            end
        end
    end
endmodule

// file: pbba_panel_model.sv
// panel model: board speaker and front-panel power indicator as a listener sees them
`timescale 1ns/10ps
module pbba_panel_model (
    // clock and pins
    input  wire logic clk,
    input  wire logic spk,
    input  wire logic led,
    // what was seen
    output int        blinks,
    output int        beeps
);
    // counters start at zero; led starts lit so power-up is no blink
    logic spk_q = 1'b0;
    logic led_q = 1'b1;
    // count lamp turn-ons and cone movements; lit at power-up is not a blink
    always @(posedge clk) begin
        spk_q <= spk;
        led_q <= led;
        if (led === 1'b1 && led_q === 1'b0) blinks <= blinks + 1;
        if (spk !== spk_q) beeps <= beeps + 1;
    end
endmodule

// file: testbench.sv
// self-checking bench for the beep and blink annunciator
`timescale 1ns/10ps
module testbench;
    import pbba_pkg::*;
    // short phases keep led patterns quick; tone instance keeps long bursts
    localparam int H = 20;
    localparam int P = 120;
    logic      clk, nrst, ce, upd_done, spk, led, busy, spk2;
    pbba_req_t req;
    int        mismatches, comparisons, cycles, blinks, beeps;
    pbba_annunciator #(.HALF_CYC(H), .PAUSE_LEN(P)) i_pbba_annunciator (.I_CLK_SYS(clk),
        .I_NRST(nrst), .I_CE(ce), .I_REQ(req), .I_UPDATE_DONE(upd_done), .O_SPEAKER(spk),
        .O_POWER_LED(led), .O_BUSY(busy));
    pbba_annunciator #(.HALF_CYC(80000), .PAUSE_LEN(P)) i_pbba_annunciator_tone (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_CE(ce), .I_REQ(req), .I_UPDATE_DONE(upd_done),
        .O_SPEAKER(spk2), .O_POWER_LED(), .O_BUSY());
    pbba_panel_model i_pbba_panel_model (.clk(clk), .spk(spk), .led(led), .blinks(blinks),
        .beeps(beeps));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, sized above both tone measurements (about 57k cycles in all)
    always @(posedge clk) begin
        cycles++;
        if (cycles == 70000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle request, returns settled two edges after it was taken
    task automatic send(input pbba_event_t code);
        @(posedge clk);
        req <= '{1'b1, code};
        @(posedge clk);
        req <= '{1'b0, PBBA_EV_NONE};
        tick(2);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // repeating blink code: n blinks then pause, checked every cycle
    task automatic pattern(input pbba_event_t code, input int n, input int periods);
        int t, ph, errs, b0, pd;
        pd = 2 * n * H + P;
        // read before the request: the model counts the first rise inside send
        b0 = blinks;
        send(code);
        errs = 0;
        check("busy", busy, 1'b1);
        for (t = 0; t < periods * pd - 1; t++) begin
            ph = (t + 1) % pd; // led already one cycle into the pattern at t = 0
            if (led !== (ph < 2 * n * H && ph % (2 * H) < H)) errs++;
            tick(1);
        end
        check("led pattern", errs, 0);
        check("blink count", blinks - b0, n * periods);
    endtask
    // cycles from the restarted divider to the first speaker edge
    task automatic tone(input pbba_event_t code, input int half);
        int  n;
        logic s;
        send(code);
        s = spk2;
        check("tone start low", s, 1'b0);
        for (n = 0; n < 50000 && spk2 === s; n++) tick(1);
        check("tone half period", n, half);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int b0;
        nrst = 1'b0;
        ce = 1'b1;
        upd_done = 1'b0;
        req = '0;
        tick(20);
        check("reset led", led, 1'b1);
        check("reset speaker", spk, 1'b0);
        check("reset busy", busy, 1'b0);
        @(posedge clk);
        nrst <= 1'b1;
        // init and self-test done: lamp dark for one phase
        for (int c = 1; c <= 2; c++) begin
            send(pbba_event_t'(c));
            check("done led off", led, 1'b0);
            tick(H - 2);
            check("done led end", led, 1'b0);
            tick(1);
            check("done led back", led, 1'b1);
            check("done idle", busy, 1'b0);
        end
        // update: dark first, lit next phase, silent, ends dark
        b0 = beeps;
        send(PBBA_EV_UPDATE);
        check("update start", led, 1'b0);
        tick(H);
        check("update lit", led, 1'b1);
        tick(3 * H);
        @(posedge clk);
        upd_done <= 1'b1;
        @(posedge clk);
        upd_done <= 1'b0;
        tick(3);
        check("update end", {busy, led}, 2'h0);
        check("update silent", beeps - b0, 0);
        // code zero starts nothing
        send(PBBA_EV_NONE);
        tick(H);
        check("no request busy", busy, 1'b0);
        pattern(PBBA_EV_VIDEO, 2, 2);
        pattern(PBBA_EV_MEMORY, 3, 2);
        pattern(PBBA_EV_THERMAL, 4, 4);
        tick(2 * H);
        check("thermal stop", {busy, led}, 2'h0);
        tone(PBBA_EV_CPU_OK, TONE_HI_HALF);
        tone(PBBA_EV_MEMORY, TONE_LO_HALF);
        report_and_stop();
    end
endmodule
